/* hdl/tcm_pkg.sv */
// Purpose: Constants and carriers for the transfer controller sequencer.
// Assumes: 24-bit internal bus, 32-bit bus data, 200 MHz i_mclk.
// Notes: Register information is three longwords: {mode A, source}, {mode B, destination},
// {count A, count B}.
package tcm_pkg;
  // Bus geometry
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam logic [23:0] VEC_BASE_DEF = 24'h000400;
  localparam logic [23:0] INFO_STRIDE = 24'h00000C;
  localparam logic [1:0] INFO_LAST = 2'h2;
  localparam logic [1:0] INT_OPS_LAST = 2'h2;
  //////////////////////////////////////////////////////////////////////////////
  // Field positions in mode_register_a / mode_register_b
  localparam int MODE_A_SM_LSB = 6;
  localparam int MODE_A_DM_LSB = 4;
  localparam int MODE_A_MD_LSB = 2;
  localparam int MODE_A_DTS = 1;
  localparam int MODE_A_SZ = 0;
  localparam int MODE_B_CHAIN = 7;
  localparam int MODE_B_EVERY = 6;
  // Field encodings
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK = 2'h2;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;
  localparam logic [1:0] BUS_BYTE = 2'h0;
  localparam logic [1:0] BUS_WORD = 2'h1;
  localparam logic [1:0] BUS_LONG = 2'h2;
  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {ST_IDLE, ST_VEC, ST_INFO, ST_RD, ST_WR, ST_INT, ST_WB} tcm_state_e;
  typedef struct packed {
    logic [7:0] mode_a;
    logic [23:0] src;
    logic [7:0] mode_b;
    logic [23:0] dst;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
  } tcm_info_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } tcm_bus_s;
  typedef struct packed {
    logic [7:0] vec;
    logic sw;
  } tcm_act_s;
  localparam tcm_bus_s BUS_RST = '0;
  localparam tcm_info_s INFO_RST = '0;
endpackage

/* hdl/tcm_transfer_controller.sv */
// Purpose: Transfer controller sequencer for normal, repeat, block and chain transfers.
// Assumes: One bus master port, request held until a one-cycle i_bus_ack.
// Notes: Access length per cycle type is set by the bus; this side waits on ack.
// How it works
// - Repeat mode moves one byte or word per activation.
// - Repeat count runs 1 to 256 per cycle.
// - Repeat end reloads counter and repeat-area address, then keeps going.
// - Repeat mode never interrupts unless every-transfer select is set.
// - Repeat: high byte is reload value, low byte counts, B ignored.
// - Block mode moves one whole block per activation.
// - Block size runs 1 to 256 units.
// - After a block, restore size counter and block-area address, step other.
// - Block count runs 1 to 65536; interrupt once all blocks are done.
// - Block: high byte size, low byte unit count, B counts blocks.
// - Chain enable runs several independent transfers for one request.
// - Activation reads the vector, then the first information set.
// - While chain enable is one, fetch the next set from following locations.
// - Chained transfers raise no interrupt and leave the source flag alone.
// - Count end or every-transfer select passes the activating interrupt on.
// - Software activation ends with the software done interrupt instead.
// - Software done keeps the activation flag set; the handler clears it.
// - No software done while a software transfer waits or runs.
// - One vector read, six info accesses, data read/write, three internal ops.
// - Info and data costs repeat for each chained transfer.
// - Internal ops take one cycle each; info and data accesses both wait on the bus ack.
// - Source and destination addresses are 24 bits, each stepped independently.
// - Updated register information is written back after the transfer.
// - Quiet software transfer clears the software activation flag.
`timescale 1ns/10ps
module tcm_transfer_controller #(
  parameter logic [23:0] VEC_BASE = tcm_pkg::VEC_BASE_DEF
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_act_req,
  input wire tcm_pkg::tcm_act_s i_act,
  output tcm_pkg::tcm_act_s o_act,
  output logic o_act_ack,
  output tcm_pkg::tcm_bus_s o_bus,
  input wire logic i_bus_ack,
  input wire logic [31:0] i_bus_rdata,
  output logic o_busy,
  output logic o_cpu_irq,
  output logic o_enable_clr,
  output logic o_src_clr,
  output logic o_sw_done_irq,
  output logic o_sw_flag_clr
);
  // Vector entries are halfwords, so the table base must be even
  if (VEC_BASE[0] != 1'b0) begin : g_bad_base
    $error("VEC_BASE must be halfword aligned");
  end

  tcm_pkg::tcm_state_e st;
  tcm_pkg::tcm_info_s info;
  tcm_pkg::tcm_info_s next_info;
  logic [23:0] ptr;
  logic [1:0] idx;
  logic done;
  logic next_done;
  logic unit_more;
  logic [8:0] nunits;
  logic [23:0] ds;
  logic [23:0] dd;
  logic [1:0] md;
  logic sz;
  logic chain;
  logic every_sel;

  // Signed step: +unit, -unit or zero, unit is 1 byte or 2
  function automatic logic [23:0] step(input logic [1:0] am, input logic s);
    logic [23:0] u;
    u = s ? 24'h000002 : 24'h000001;
    if (am == tcm_pkg::AM_INC) begin
      return u;
    end
    if (am == tcm_pkg::AM_DEC) begin
      return 24'(-u);
    end
    return 24'h000000;
  endfunction

  // Start of the area: undo all but the last step of n units
  function automatic logic [23:0] restore(input logic [23:0] a, input logic [23:0] d,
                                          input logic [8:0] n);
    return 24'(a + d - 24'(d * {15'h0000, n}));
  endfunction

  // Longword of the information set, for write-back
  function automatic logic [31:0] info_word(input tcm_pkg::tcm_info_s f, input logic [1:0] i);
    unique case (i)
      2'h0: return {f.mode_a, f.src};
      2'h1: return {f.mode_b, f.dst};
      default: return {f.cnt_a, f.cnt_b};
    endcase
  endfunction

  assign md = info.mode_a[tcm_pkg::MODE_A_MD_LSB +: 2];
  assign sz = info.mode_a[tcm_pkg::MODE_A_SZ];
  assign chain = info.mode_b[tcm_pkg::MODE_B_CHAIN];
  assign every_sel = info.mode_b[tcm_pkg::MODE_B_EVERY];
  assign ds = step(info.mode_a[tcm_pkg::MODE_A_SM_LSB +: 2], sz);
  assign dd = step(info.mode_a[tcm_pkg::MODE_A_DM_LSB +: 2], sz);
  assign nunits = (info.cnt_a[15:8] == 8'h00) ? 9'h100 : {1'b0, info.cnt_a[15:8]};

  //////////////////////////////////////////////////////////////////////////////
  // Counter and address update at the end of each data write
  // Both addresses step on every unit; only the area side is pulled back
  always_comb begin
    next_info = info;
    next_done = 1'b0;
    unit_more = 1'b0;
    next_info.src = 24'(info.src + ds);
    next_info.dst = 24'(info.dst + dd);
    unique case (md)
      tcm_pkg::MD_REPEAT: begin
        next_info.cnt_a[7:0] = 8'(info.cnt_a[7:0] - 8'h01);
        if (info.cnt_a[7:0] == 8'h01) begin
          next_info.cnt_a[7:0] = info.cnt_a[15:8];
          if (info.mode_a[tcm_pkg::MODE_A_DTS]) begin
            next_info.src = restore(info.src, ds, nunits);
          end else begin
            next_info.dst = restore(info.dst, dd, nunits);
          end
        end
      end
      tcm_pkg::MD_BLOCK: begin
        next_info.cnt_a[7:0] = 8'(info.cnt_a[7:0] - 8'h01);
        unit_more = (info.cnt_a[7:0] != 8'h01);
        if (!unit_more) begin
          next_info.cnt_a[7:0] = info.cnt_a[15:8];
          next_info.cnt_b = 16'(info.cnt_b - 16'h0001);
          next_done = (info.cnt_b == 16'h0001);
          if (info.mode_a[tcm_pkg::MODE_A_DTS]) begin
            next_info.src = restore(info.src, ds, nunits);
          end else begin
            next_info.dst = restore(info.dst, dd, nunits);
          end
        end
      end
      default: begin
        next_info.cnt_a = 16'(info.cnt_a - 16'h0001);
        next_done = (info.cnt_a == 16'h0001);
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and bus master; bus states move on the bus ack, ST_IDLE on the request, ST_INT on its op count
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st <= tcm_pkg::ST_IDLE;
      o_bus <= tcm_pkg::BUS_RST;
      o_act <= '0;
      o_act_ack <= 1'b0;
      ptr <= 24'h000000;
      idx <= 2'h0;
    end else begin
      o_act_ack <= 1'b0;
      unique case (st)
        tcm_pkg::ST_IDLE: begin
          if (i_act_req) begin
            o_act <= i_act;
            o_act_ack <= 1'b1;
            st <= tcm_pkg::ST_VEC;
            o_bus <= '{1'b1, 1'b0, tcm_pkg::BUS_WORD,
                       24'(VEC_BASE + {15'h0000, i_act.vec, 1'b0}), 32'h00000000};
          end
        end
        tcm_pkg::ST_VEC: begin
          if (i_bus_ack) begin
            ptr <= {8'h00, i_bus_rdata[15:0]};
            idx <= 2'h0;
            st <= tcm_pkg::ST_INFO;
            o_bus.size <= tcm_pkg::BUS_LONG;
            o_bus.addr <= {8'h00, i_bus_rdata[15:0]};
          end
        end
        tcm_pkg::ST_INFO: begin
          if (i_bus_ack) begin
            idx <= 2'(idx + 2'h1);
            o_bus.addr <= 24'(o_bus.addr + 24'h000004);
            if (idx == tcm_pkg::INFO_LAST) begin
              st <= tcm_pkg::ST_RD;
              o_bus.size <= sz ? tcm_pkg::BUS_WORD : tcm_pkg::BUS_BYTE;
              o_bus.addr <= info.src;
            end
          end
        end
        tcm_pkg::ST_RD: begin
          if (i_bus_ack) begin
            st <= tcm_pkg::ST_WR;
            o_bus.we <= 1'b1;
            o_bus.addr <= info.dst;
            o_bus.wdata <= sz ? {16'h0000, i_bus_rdata[15:0]} : {24'h000000, i_bus_rdata[7:0]};
          end
        end
        tcm_pkg::ST_WR: begin
          if (i_bus_ack) begin
            o_bus.we <= 1'b0;
            if (unit_more) begin
              st <= tcm_pkg::ST_RD;
              o_bus.addr <= next_info.src;
            end else begin
              st <= tcm_pkg::ST_INT;
              o_bus.req <= 1'b0;
              idx <= 2'h0;
            end
          end
        end
        tcm_pkg::ST_INT: begin
          // Three single-cycle internal operations before write-back
          idx <= 2'(idx + 2'h1);
          if (idx == tcm_pkg::INT_OPS_LAST) begin
            st <= tcm_pkg::ST_WB;
            idx <= 2'h0;
            o_bus <= '{1'b1, 1'b1, tcm_pkg::BUS_LONG, ptr, info_word(info, 2'h0)};
          end
        end
        tcm_pkg::ST_WB: begin
          if (i_bus_ack) begin
            idx <= 2'(idx + 2'h1);
            o_bus.addr <= 24'(o_bus.addr + 24'h000004);
            o_bus.wdata <= info_word(info, 2'(idx + 2'h1));
            if (idx == tcm_pkg::INFO_LAST) begin
              idx <= 2'h0;
              if (chain) begin
                st <= tcm_pkg::ST_INFO;
                ptr <= 24'(ptr + tcm_pkg::INFO_STRIDE);
                o_bus.we <= 1'b0;
                o_bus.addr <= 24'(ptr + tcm_pkg::INFO_STRIDE);
              end else begin
                st <= tcm_pkg::ST_IDLE;
                o_bus <= tcm_pkg::BUS_RST;
              end
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register information image and count-end flag
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      info <= tcm_pkg::INFO_RST;
      done <= 1'b0;
    end else if (st == tcm_pkg::ST_INFO && i_bus_ack) begin
      done <= 1'b0;
      unique case (idx)
        2'h0: {info.mode_a, info.src} <= i_bus_rdata;
        2'h1: {info.mode_b, info.dst} <= i_bus_rdata;
        default: {info.cnt_a, info.cnt_b} <= i_bus_rdata;
      endcase
    end else if (st == tcm_pkg::ST_WR && i_bus_ack) begin
      info <= next_info;
      done <= next_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Completion pulses, decided only at the final write-back of the chain
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_cpu_irq <= 1'b0;
      o_enable_clr <= 1'b0;
      o_src_clr <= 1'b0;
      o_sw_done_irq <= 1'b0;
      o_sw_flag_clr <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_busy <= (st != tcm_pkg::ST_IDLE) || i_act_req;
      o_cpu_irq <= 1'b0;
      o_enable_clr <= 1'b0;
      o_src_clr <= 1'b0;
      o_sw_done_irq <= 1'b0;
      o_sw_flag_clr <= 1'b0;
      if (st == tcm_pkg::ST_WB && i_bus_ack && idx == tcm_pkg::INFO_LAST && !chain) begin
        if (o_act.sw) begin
          o_sw_done_irq <= done || every_sel;
          o_sw_flag_clr <= !(done || every_sel);
        end else begin
          o_cpu_irq <= done || every_sel;
          o_enable_clr <= done || every_sel;
          o_src_clr <= !(done || every_sel);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence s_wr_end;
    st == tcm_pkg::ST_WR && i_bus_ack;
  endsequence
  sequence s_chain_end;
    st == tcm_pkg::ST_WB && i_bus_ack && idx == tcm_pkg::INFO_LAST && chain;
  endsequence

  chk_vec_first: assert property (st == tcm_pkg::ST_IDLE && i_act_req |=>
    o_bus.req && !o_bus.we && o_bus.addr == 24'(VEC_BASE + {15'h0000, $past(i_act.vec), 1'b0}))
    else $error("vector read not issued first");
  chk_three_ops: assert property ($rose(st == tcm_pkg::ST_INT) |->
    (st == tcm_pkg::ST_INT)[*3] ##1 (st == tcm_pkg::ST_WB && o_bus.we))
    else $error("internal operation count wrong");
  chk_chain_quiet: assert property (s_chain_end |=>
    st == tcm_pkg::ST_INFO && !o_cpu_irq && !o_src_clr && !o_sw_done_irq && !o_enable_clr)
    else $error("chained transfer signalled completion");
  chk_chain_next: assert property (s_chain_end |=>
    o_bus.addr == 24'($past(ptr) + tcm_pkg::INFO_STRIDE))
    else $error("next information set not contiguous");
  chk_irq_cause: assert property ((o_cpu_irq || o_sw_done_irq) |->
    $past(done) || $past(every_sel))
    else $error("interrupt without count end or select");
  chk_sw_done: assert property (o_sw_done_irq |-> $past(o_act.sw) && !o_cpu_irq
    && st == tcm_pkg::ST_IDLE)
    else $error("software done raised wrongly");
  chk_sw_clear: assert property (o_sw_flag_clr |-> $past(o_act.sw) && !$past(done)
    && !$past(every_sel) && !o_sw_done_irq)
    else $error("software flag cleared wrongly");
  chk_block_units: assert property (s_wr_end ##0 (md == tcm_pkg::MD_BLOCK &&
    info.cnt_a[7:0] != 8'h01) |=> st == tcm_pkg::ST_RD && o_bus.addr == info.src)
    else $error("block ended early");
  chk_repeat_reload: assert property (s_wr_end ##0 (md == tcm_pkg::MD_REPEAT &&
    info.cnt_a[7:0] == 8'h01) |=> info.cnt_a[7:0] == info.cnt_a[15:8] && !done)
    else $error("repeat counter not reloaded");
  chk_step_size: assert property (s_wr_end ##0
    ((md == tcm_pkg::MD_NORMAL || !info.mode_a[tcm_pkg::MODE_A_DTS]) &&
    info.mode_a[tcm_pkg::MODE_A_SM_LSB +: 2] == tcm_pkg::AM_INC) |=>
    info.src == 24'($past(info.src) + (sz ? 24'h000002 : 24'h000001)))
    else $error("source step size wrong");
endmodule

/* test/tcm_bus_mem_model.sv */
// Purpose: Behavioural internal bus memory that answers the transfer controller.
// Assumes: Byte-addressed store of 32-bit entries, one entry per address, 4 KB window.
// Notes: The ack latency comes from i_lat, so the same model serves prompt and slow cases.
`timescale 1ns/10ps
module tcm_bus_mem_model (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire tcm_pkg::tcm_bus_s i_bus,
  input wire logic [3:0] i_lat,
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic [7:0] o_rd_cnt,
  output logic [7:0] o_wr_cnt
);
  logic [31:0] mem [0:4095];
  logic [3:0] wait_cnt;
  logic [31:0] last = '0;
  //////////////////////////////////////////////////////////////////////////////
  // One-cycle ack after i_lat waiting cycles; stands in for slow access states
  always @(posedge i_mclk) begin
    if (i_srst || o_ack || !i_bus.req) begin
      o_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= i_lat) begin
      o_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // Store writes and count completed accesses of each kind
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rd_cnt <= 8'h00;
      o_wr_cnt <= 8'h00;
    end else if (o_ack && i_bus.we) begin
      mem[i_bus.addr[11:0]] <= i_bus.wdata;
      o_wr_cnt <= o_wr_cnt + 8'h01;
    end else if (o_ack) begin
      o_rd_cnt <= o_rd_cnt + 8'h01;
    end
  end
  // Read data only valid with ack; otherwise it toggles so stale data never looks right
  always @(posedge i_mclk) begin
    last <= o_rdata;
  end
  assign o_rdata = o_ack ? mem[i_bus.addr[11:0]] : ~last;
endmodule

/* test/transfer_controller_modes_tb.sv */
// Purpose: Self-checking bench for repeat, block, chain and completion behaviour.
// Assumes: Default vector base, register information kept in the memory model.
// Notes: Each scenario preloads memory, activates once or twice and checks the writeback.
`timescale 1ns/10ps
module transfer_controller_modes_tb;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_act_req = 1'b0;
  tcm_pkg::tcm_act_s i_act = '0;
  tcm_pkg::tcm_bus_s o_bus;
  tcm_pkg::tcm_act_s o_act;
  logic o_act_ack, i_bus_ack, o_busy, o_cpu_irq, o_enable_clr, o_src_clr;
  logic o_sw_done_irq, o_sw_flag_clr;
  logic [31:0] i_bus_rdata;
  logic [3:0] lat = 4'h0;
  logic [7:0] rd_cnt, wr_cnt;
  int fail_count = 0;
  int compares = 0;
  // 200 MHz clock
  always #2.5 i_mclk = ~i_mclk;
  //////////////////////////////////////////////////////////////////////////////
  tcm_transfer_controller dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_act_req(i_act_req),
    .i_act(i_act), .o_act(o_act), .o_act_ack(o_act_ack), .o_bus(o_bus), .i_bus_ack(i_bus_ack),
    .i_bus_rdata(i_bus_rdata), .o_busy(o_busy), .o_cpu_irq(o_cpu_irq),
    .o_enable_clr(o_enable_clr), .o_src_clr(o_src_clr), .o_sw_done_irq(o_sw_done_irq),
    .o_sw_flag_clr(o_sw_flag_clr));
  tcm_bus_mem_model mem_m (.i_mclk(i_mclk), .i_srst(i_srst), .i_bus(o_bus), .i_lat(lat),
    .o_ack(i_bus_ack), .o_rdata(i_bus_rdata), .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt));
  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic put_info(input logic [11:0] a, input logic [7:0] mode_a,
      input logic [23:0] src, input logic [7:0] mode_b, input logic [23:0] dst,
      input logic [31:0] cr);
    mem_m.mem[a] = {mode_a, src};
    mem_m.mem[a + 12'h004] = {mode_b, dst};
    mem_m.mem[a + 12'h008] = cr;
  endtask
  // Addresses and counts as written back; mode bytes are left alone
  task automatic chk_info(input string name, input logic [11:0] a, input logic [23:0] src,
      input logic [23:0] dst, input logic [31:0] cr);
    chk({name, " src"}, {8'h00, src}, {8'h00, mem_m.mem[a][23:0]});
    chk({name, " dst"}, {8'h00, dst}, {8'h00, mem_m.mem[a + 12'h004][23:0]});
    chk({name, " cnt"}, cr, mem_m.mem[a + 12'h008]);
  endtask
  // Activate, wait for the completion pulse, judge pulses and access counts
  task automatic run(input logic [7:0] vec, input logic sw, input logic [11:0] start,
      input logic [4:0] exp, input logic [7:0] n_rd, input logic [7:0] n_wr);
    logic [7:0] rd0;
    logic [7:0] wr0;
    logic [4:0] seen;
    int k;
    rd0 = rd_cnt;
    wr0 = wr_cnt;
    seen = 5'h00;
    k = 0;
    mem_m.mem[12'h400 + {3'h0, vec, 1'b0}] = {16'hDEAD, 4'h0, start};
    @(negedge i_mclk);
    i_act_req = 1'b1;
    i_act = {vec, sw};
    while (o_act_ack !== 1'b1 && k < 20) begin
      @(negedge i_mclk);
      k++;
    end
    i_act_req = 1'b0;
    chk("act ack", 32'h1, {31'h0, o_act_ack});
    chk("act held", {23'h0, vec, sw}, {23'h0, o_act});
    chk("vector addr", {8'h00, 24'h000400 + {15'h0000, vec, 1'b0}}, {8'h00, o_bus.addr});
    chk("busy", 32'h1, {31'h0, o_busy});
    while (seen == 5'h00 && k < 400) begin
      @(negedge i_mclk);
      k++;
      seen = {o_cpu_irq, o_enable_clr, o_src_clr, o_sw_done_irq, o_sw_flag_clr};
    end
    chk("pulses", {27'h0, exp}, {27'h0, seen});
    chk("reads", {24'h0, n_rd}, {24'h0, 8'(rd_cnt - rd0)});
    chk("writes", {24'h0, n_wr}, {24'h0, 8'(wr_cnt - wr0)});
    @(negedge i_mclk);
    chk("idle", 32'h0, {31'h0, o_busy});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Repeat byte, size 2: second activation wraps and reloads
  task automatic test_repeat();
    lat = 4'h0;
    put_info(12'h100, 8'hA6, 24'h000200, 8'h00, 24'h000300, 32'h0202_1234);
    mem_m.mem[12'h200] = 32'hFFFF_FF5A;
    mem_m.mem[12'h201] = 32'h1234_56C3;
    run(8'h03, 1'b0, 12'h100, 5'b00100, 8'h05, 8'h04);
    chk("repeat data 0", 32'h0000_005A, mem_m.mem[12'h300]);
    chk_info("repeat 1", 12'h100, 24'h000201, 24'h000301, 32'h0201_1234);
    run(8'h03, 1'b0, 12'h100, 5'b00100, 8'h05, 8'h04);
    chk("repeat data 1", 32'h0000_00C3, mem_m.mem[12'h301]);
    chk_info("repeat 2", 12'h100, 24'h000200, 24'h000302, 32'h0202_1234);
    $display("test repeat done");
  endtask
  // Block of two words, one block, destination is the block area, slow bus
  task automatic test_block();
    lat = 4'h2;
    put_info(12'h120, 8'hA9, 24'h000220, 8'h00, 24'h000320, 32'h0202_0001);
    mem_m.mem[12'h220] = 32'hABCD_1111;
    mem_m.mem[12'h222] = 32'hABCD_2222;
    run(8'h05, 1'b0, 12'h120, 5'b11000, 8'h06, 8'h05);
    chk("block data 0", 32'h0000_1111, mem_m.mem[12'h320]);
    chk("block data 1", 32'h0000_2222, mem_m.mem[12'h322]);
    chk_info("block", 12'h120, 24'h000224, 24'h000320, 32'h0202_0000);
    $display("test block done");
  endtask
  // Two chained entries, software activation, select set on both
  task automatic test_chain();
    lat = 4'h1;
    put_info(12'h140, 8'h80, 24'h000240, 8'hC0, 24'h000340, 32'h0005_0000);
    put_info(12'h14C, 8'h00, 24'h000241, 8'h40, 24'h000341, 32'h0003_0000);
    mem_m.mem[12'h240] = 32'h0000_0077;
    mem_m.mem[12'h241] = 32'h0000_0088;
    run(8'h07, 1'b1, 12'h140, 5'b00010, 8'h09, 8'h08);
    chk("chain data 0", 32'h0000_0077, mem_m.mem[12'h340]);
    chk("chain data 1", 32'h0000_0088, mem_m.mem[12'h341]);
    chk_info("chain 0", 12'h140, 24'h000241, 24'h000340, 32'h0004_0000);
    chk_info("chain 1", 12'h14C, 24'h000241, 24'h000341, 32'h0002_0000);
    $display("test chain done");
  endtask
  // Normal word with decrementing addresses: quiet software end, then count end
  task automatic test_normal();
    lat = 4'h0;
    put_info(12'h160, 8'hF1, 24'h000262, 8'h00, 24'h000366, 32'h0003_0000);
    mem_m.mem[12'h262] = 32'h0000_4455;
    mem_m.mem[12'h260] = 32'h0000_9999;
    run(8'h09, 1'b1, 12'h160, 5'b00001, 8'h05, 8'h04);
    chk("normal data 0", 32'h0000_4455, mem_m.mem[12'h366]);
    chk_info("normal 1", 12'h160, 24'h000260, 24'h000364, 32'h0002_0000);
    mem_m.mem[12'h168] = 32'h0001_0000;
    run(8'h09, 1'b0, 12'h160, 5'b11000, 8'h05, 8'h04);
    chk("normal data 1", 32'h0000_9999, mem_m.mem[12'h364]);
    $display("test normal done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Whole run is a few hundred cycles; 10000 cycles means a hang
  initial begin
    #50000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge i_mclk);
    i_srst = 1'b0;
    test_repeat();
    test_block();
    test_chain();
    test_normal();
    wrap_up();
  end
endmodule
